// file: design/cdid_core.sv
// Purpose: instruction interpreter of a 20x4 character display controller
// Assumes: host strobes synchronous to clk, one access per strobe
// Notes:   reg_select low = instruction side, high = data side
//
// How it works
// - clear fills text RAM with spaces
// - clear homes counter, unshifts, sets increment
// - home zeroes counter and shift, targets text RAM
// - entry mode stores direction; shift follows it
// - auto shift only on text RAM writes
// - display on bit blanks or shows panel
// - cursor shown as bottom row at counter
// - blink alternates cursor char with all-on
// - cursor/shift steps counter, optionally shifts display
// - cursor/shift makes counter target text RAM
// - function set selects 4 or 8 bit bus
// - function set stores line count bit
// - luminance field sets panel brightness duty
// - glyph address command loads six-bit address
// - text address command loads seven-bit address
// - instruction read returns counter, busy zero
// - every access taken at once, never busy
// - data write stores byte, steps, maybe shifts
// - data read returns byte then steps counter
// - settings commands leave RAMs and counter alone
// - power-up defaults for text RAM and settings
// - row to text address map with rotation
// - codes 0x00-0x0f pick eight user glyphs
`timescale 1ns/1ns
module cdid_core #(
  parameter int unsigned BLINK_HALF_CYC = cdid_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // host access port
  input  wire logic       reg_select,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // settings seen by the panel driver
  output logic            display_on,
  output logic            cursor_on,
  output logic            blink_on,
  output logic            bus_width_sel,
  output logic            two_lines,
  output logic            luminance_hi,
  output logic            luminance_lo,
  output logic            panel_enable,
  output logic      [5:0] display_offset,
  output logic      [6:0] address_counter,
  // scan-out lookup
  input  wire logic [1:0] scan_row,
  input  wire logic [4:0] scan_col,
  input  wire logic [2:0] scan_pix_row,
  output logic      [7:0] scan_code,
  output logic            scan_is_glyph,
  output logic      [4:0] scan_pixels
);
  // ----------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------
  logic [7:0]  text_ram  [cdid_pkg::TEXT_DEPTH];
  logic [7:0]  glyph_ram [cdid_pkg::GLYPH_DEPTH];
  logic [cdid_pkg::TEXT_DEPTH-1:0] text_written_r;
  logic [6:0]  addr_r;
  logic        addr_glyph_r;
  logic [5:0]  shift_r;
  logic        id_r, s_r, d_r, c_r, b_r, wide_r, n_r;
  logic [1:0]  lum_r;
  logic        nib_phase_r;
  logic [3:0]  nib_hi_r;
  logic [7:0]  rdata_r;
  logic [24:0] blink_cnt_r;
  logic        blink_phase_r;
  logic [1:0]  pwm_cnt_r;
  logic        panel_r;

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  logic       acc;
  logic       acc_done;
  logic [7:0] byte_in;
  logic       cmd_wr, dat_wr, dat_rd;
  logic [7:0] cur_byte;
  logic [6:0] addr_step;
  logic       text_shift_wr;

  assign acc = wr_stb | rd_stb;
  // in four-bit mode only the second nibble completes the byte
  assign acc_done = acc & (wide_r | nib_phase_r);
  assign byte_in  = wide_r ? wdata : {nib_hi_r, wdata[7:4]};
  assign cmd_wr   = acc_done & wr_stb & ~reg_select;
  assign dat_wr   = acc_done & wr_stb &  reg_select;
  assign dat_rd   = acc_done & rd_stb &  reg_select;

  // unwritten text locations read as space, so clear costs one cycle
  always_comb begin
    if (addr_glyph_r) begin
      cur_byte = glyph_ram[addr_r[5:0]];
    end else if (text_written_r[addr_r]) begin
      cur_byte = text_ram[addr_r];
    end else begin
      cur_byte = cdid_pkg::SPACE_CODE;
    end
  end

  // counter step per direction bit; glyph addresses wrap at six bits
  always_comb begin
    addr_step = id_r ? addr_r + 7'h01 : addr_r - 7'h01;
    if (addr_glyph_r) begin
      addr_step[6] = 1'b0;
    end
  end

  assign text_shift_wr = dat_wr & ~addr_glyph_r & s_r;

  // ----------------------------------------------------------------------
  // nibble pairing for the four-bit bus
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nib_phase_r <= 1'b0;
      nib_hi_r    <= 4'h0;
    end else if (cmd_wr && byte_in[cdid_pkg::OP_FUNC +: 3] == 3'h1) begin
      nib_phase_r <= 1'b0;  // width change restarts pairing
    end else if (acc && !wide_r) begin
      nib_phase_r <= ~nib_phase_r;
      if (!nib_phase_r) begin
        nib_hi_r <= wdata[7:4];
      end
    end
  end

  // ----------------------------------------------------------------------
  // address counter and target RAM
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_r       <= cdid_pkg::RST_ADDR;
      addr_glyph_r <= 1'b0;
    end else if (cmd_wr) begin
      if (byte_in[cdid_pkg::OP_TEXT_ADDR]) begin
        addr_r       <= byte_in[6:0];
        addr_glyph_r <= 1'b0;
      end else if (byte_in[cdid_pkg::OP_GLYPH_ADDR]) begin
        addr_r       <= {1'b0, byte_in[5:0]};
        addr_glyph_r <= 1'b1;
      end else if (byte_in[cdid_pkg::OP_FUNC]) begin
        addr_r <= addr_r;
      end else if (byte_in[cdid_pkg::OP_SHIFT]) begin
        addr_r       <= byte_in[cdid_pkg::F_RL] ? addr_r + 7'h01
                                                : addr_r - 7'h01;
        addr_glyph_r <= 1'b0;
      end else if (byte_in[cdid_pkg::OP_DISP] ||
                   byte_in[cdid_pkg::OP_ENTRY]) begin
        addr_r <= addr_r;
      end else if (byte_in[cdid_pkg::OP_HOME] ||
                   byte_in[cdid_pkg::OP_CLEAR]) begin
        addr_r       <= cdid_pkg::RST_ADDR;
        addr_glyph_r <= 1'b0;
      end
    end else if (dat_wr || dat_rd) begin
      addr_r <= addr_step;
    end
  end

  // ----------------------------------------------------------------------
  // display shift offset, rotating within each 40-location line
  // ----------------------------------------------------------------------
  logic [5:0] shift_left, shift_right;
  assign shift_left  = (shift_r == cdid_pkg::LINE_LEN - 6'h01) ? 6'h00
                                                               : shift_r + 6'h01;
  assign shift_right = (shift_r == 6'h00) ? cdid_pkg::LINE_LEN - 6'h01
                                          : shift_r - 6'h01;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= cdid_pkg::RST_SHIFT;
    end else if (cmd_wr) begin
      if (byte_in[7:4] == 4'h1 && byte_in[cdid_pkg::F_SC]) begin
        shift_r <= byte_in[cdid_pkg::F_RL] ? shift_right
                                           : shift_left;
      end else if (byte_in[7:2] == 6'h00 && byte_in[1:0] != 2'h0) begin
        shift_r <= cdid_pkg::RST_SHIFT;
      end
    end else if (text_shift_wr) begin
      shift_r <= id_r ? shift_left : shift_right;
    end
  end

  // ----------------------------------------------------------------------
  // entry mode, display control and function set settings
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      id_r  <= cdid_pkg::RST_ID;
      s_r   <= cdid_pkg::RST_S;
      d_r   <= cdid_pkg::RST_D;
      c_r   <= cdid_pkg::RST_C;
      b_r   <= cdid_pkg::RST_B;
      wide_r <= cdid_pkg::RST_WIDE;
      n_r   <= cdid_pkg::RST_N;
      lum_r <= cdid_pkg::RST_LUM;
    end else if (cmd_wr) begin
      case (byte_in[7:2])
        6'h00: begin
          if (byte_in[cdid_pkg::OP_CLEAR] && !byte_in[cdid_pkg::OP_HOME]) begin
            id_r <= 1'b1;
          end
        end
        6'h01: begin
          id_r <= byte_in[cdid_pkg::F_ID];
          s_r  <= byte_in[cdid_pkg::F_S];
        end
        6'h02, 6'h03: begin
          d_r <= byte_in[cdid_pkg::F_D];
          c_r <= byte_in[cdid_pkg::F_C];
          b_r <= byte_in[cdid_pkg::F_B];
        end
        6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f: begin
          wide_r <= byte_in[cdid_pkg::F_WIDE];
          n_r    <= byte_in[cdid_pkg::F_N];
          lum_r  <= {byte_in[cdid_pkg::F_LUM1],
                     byte_in[cdid_pkg::F_LUM0]};
        end
        default: begin
          id_r <= id_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // text RAM: written flags give a one-cycle clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      text_written_r <= '0;
    end else if (cmd_wr && byte_in == 8'h01) begin
      text_written_r <= '0;
    end else if (dat_wr && !addr_glyph_r) begin
      text_written_r[addr_r] <= 1'b1;
    end
  end

  // RAM arrays carry no reset; glyph RAM survives clear
  always_ff @(posedge clk) begin
    if (dat_wr) begin
      if (addr_glyph_r) begin
        glyph_ram[addr_r[5:0]] <= byte_in;
      end else begin
        text_ram[addr_r] <= byte_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data, valid only in the cycle after the read strobe
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;
  assign rd_byte = reg_select ? cur_byte
                              : {1'b0, addr_r};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (rd_stb) begin
      if (wide_r) begin
        rdata_r <= rd_byte;
      end else begin
        rdata_r <= nib_phase_r ? {rd_byte[3:0], 4'h0}
                               : {rd_byte[7:4], 4'h0};
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // blink timebase and brightness duty
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_r   <= 25'h0;
      blink_phase_r <= 1'b0;
    end else if (blink_cnt_r == 25'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_r   <= 25'h0;
      blink_phase_r <= ~blink_phase_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 25'h1;
    end
  end

  // four-slot duty: 4, 3, 2 or 1 slots lit for codes 00..11
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_cnt_r <= 2'h0;
      panel_r   <= 1'b0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 2'h1;
      panel_r   <= d_r && (pwm_cnt_r <= ~lum_r);
    end
  end

  // ----------------------------------------------------------------------
  // scan lookup: stage one maps position to code, stage two to pixels
  // ----------------------------------------------------------------------
  logic [6:0] pos_sum;
  logic [5:0] pos;
  logic [6:0] scan_addr;
  logic [7:0] scan_code_r;
  logic       scan_cursor_r;
  logic [2:0] scan_prow_r;
  logic [4:0] scan_pix_r;

  always_comb begin
    pos_sum = {1'b0, shift_r} + {2'b0, scan_col}
            + (scan_row[1] ? {1'b0, cdid_pkg::ROW_LEN} : 7'h00);
    if (pos_sum >= {1'b0, cdid_pkg::LINE_LEN}) begin
      pos_sum = pos_sum - {1'b0, cdid_pkg::LINE_LEN};
    end
    pos       = pos_sum[5:0];
    scan_addr = (scan_row[0] ? cdid_pkg::LINE2_BASE : 7'h00)
              + {1'b0, pos};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_code_r   <= 8'h00;
      scan_cursor_r <= 1'b0;
      scan_prow_r   <= 3'h0;
    end else begin
      scan_code_r   <= text_written_r[scan_addr] ? text_ram[scan_addr]
                                                 : cdid_pkg::SPACE_CODE;
      scan_cursor_r <= !addr_glyph_r && (scan_addr == addr_r);
      scan_prow_r   <= scan_pix_row;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_pix_r <= 5'h00;
    end else if (!d_r) begin
      scan_pix_r <= 5'h00;
    end else if (scan_cursor_r && b_r && blink_phase_r) begin
      scan_pix_r <= 5'h1f;
    end else if (scan_cursor_r && c_r &&
                 scan_prow_r == cdid_pkg::CURSOR_ROW) begin
      scan_pix_r <= 5'h1f;
    end else if (scan_code_r < cdid_pkg::GLYPH_LIMIT) begin
      scan_pix_r <= glyph_ram[{scan_code_r[2:0], scan_prow_r}][4:0];
    end else begin
      scan_pix_r <= 5'h00;  // font ROM rows come from outside
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata           = rdata_r;
  assign display_on      = d_r;
  assign cursor_on       = c_r;
  assign blink_on        = b_r;
  assign bus_width_sel   = wide_r;
  assign two_lines       = n_r;
  assign luminance_hi    = lum_r[1];
  assign luminance_lo    = lum_r[0];
  assign panel_enable    = panel_r;
  assign display_offset  = shift_r;
  assign address_counter = addr_r;
  assign scan_code       = scan_code_r;
  assign scan_is_glyph   = scan_code_r < cdid_pkg::GLYPH_LIMIT;
  assign scan_pixels     = scan_pix_r;
endmodule : cdid_core

// file: design/cdid_pkg.sv
// Purpose: constants shared by the character display instruction decoder
// Assumes: 50 MHz system clock
// Notes:   one place for every opcode bit, reset value and timing figure
package cdid_pkg;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned TEXT_DEPTH   = 128;
  localparam int unsigned GLYPH_DEPTH  = 64;
  localparam logic [5:0]  LINE_LEN     = 6'h28;  // 40 locations per line
  localparam logic [5:0]  ROW_LEN      = 6'h14;  // 20 columns per row
  localparam logic [6:0]  LINE2_BASE   = 7'h40;
  localparam logic [7:0]  SPACE_CODE   = 8'h20;
  localparam logic [7:0]  GLYPH_LIMIT  = 8'h10;  // codes below are glyphs
  localparam logic [2:0]  CURSOR_ROW   = 3'h7;   // bottom pixel row

  // ----------------------------------------------------------------------
  // instruction opcode bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned OP_TEXT_ADDR  = 7;
  localparam int unsigned OP_GLYPH_ADDR = 6;
  localparam int unsigned OP_FUNC       = 5;
  localparam int unsigned OP_SHIFT      = 4;
  localparam int unsigned OP_DISP       = 3;
  localparam int unsigned OP_ENTRY      = 2;
  localparam int unsigned OP_HOME       = 1;
  localparam int unsigned OP_CLEAR      = 0;
  // field positions inside the opcodes
  localparam int unsigned F_ID   = 1;  // entry: step direction
  localparam int unsigned F_S    = 0;  // entry: shift enable
  localparam int unsigned F_D    = 2;  // display on
  localparam int unsigned F_C    = 1;  // cursor on
  localparam int unsigned F_B    = 0;  // blink on
  localparam int unsigned F_SC   = 3;  // shift select
  localparam int unsigned F_RL   = 2;  // shift direction
  localparam int unsigned F_WIDE = 4;  // bus width
  localparam int unsigned F_N    = 3;  // line count
  localparam int unsigned F_LUM1 = 1;
  localparam int unsigned F_LUM0 = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic       RST_ID    = 1'b1;
  localparam logic       RST_S     = 1'b0;
  localparam logic       RST_D     = 1'b0;
  localparam logic       RST_C     = 1'b0;
  localparam logic       RST_B     = 1'b0;
  localparam logic       RST_WIDE  = 1'b1;
  localparam logic       RST_N     = 1'b1;
  localparam logic [1:0] RST_LUM   = 2'h0;
  localparam logic [6:0] RST_ADDR  = 7'h00;
  localparam logic [5:0] RST_SHIFT = 6'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned BLINK_HALF_MS  = 500;  // 1 Hz, equal halves
  localparam int unsigned BLINK_HALF_CYC =
    BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
endpackage : cdid_pkg

// file: tb/cdid_core_properties.sv
// Purpose: port-level assertions for the instruction decoder
// Assumes: eight-bit bus for the opcode checks, one clock domain
// Notes:   four-bit transfers are judged by the bench instead
`timescale 1ns/1ns
module cdid_core_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // host access port
  input wire logic       reg_select,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  // settings
  input wire logic       display_on,
  input wire logic       cursor_on,
  input wire logic       blink_on,
  input wire logic       bus_width_sel,
  input wire logic       two_lines,
  input wire logic       luminance_hi,
  input wire logic       luminance_lo,
  input wire logic [5:0] display_offset,
  input wire logic [6:0] address_counter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // a whole instruction byte; nibble pairs are left to the bench
  logic cmd8;
  assign cmd8 = wr_stb && !reg_select && bus_width_sel;

  AST_AC_READ: assert property (rd_stb && !reg_select && bus_width_sel
    |=> rdata == {1'b0, $past(address_counter)}) else $error("ac read bad");
  AST_RDATA_QUIET: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("rdata not quiet");
  AST_CLEAR: assert property (cmd8 && wdata == 8'h01
    |=> address_counter == 7'h00 && display_offset == 6'h00)
    else $error("clear did not home");
  AST_HOME: assert property (cmd8 && wdata[7:1] == 7'h01
    |=> address_counter == 7'h00 && display_offset == 6'h00)
    else $error("home did not home");
  AST_DISP_CTRL: assert property (cmd8 && wdata[7:3] == 5'h01
    |=> {display_on, cursor_on, blink_on} == $past(wdata[2:0])
    && $stable(address_counter)) else $error("display control bad");
  AST_FUNC_SET: assert property (cmd8 && wdata[7:5] == 3'h1
    |=> {bus_width_sel, two_lines, luminance_hi, luminance_lo}
    == {$past(wdata[4:3]), $past(wdata[1:0])}) else $error("func set bad");
  AST_GLYPH_ADDR: assert property (cmd8 && wdata[7:6] == 2'b01
    |=> address_counter == {1'b0, $past(wdata[5:0])})
    else $error("glyph address bad");
  AST_TEXT_ADDR: assert property (cmd8 && wdata[7]
    |=> address_counter == $past(wdata[6:0])) else $error("text addr bad");
  AST_IDLE_HOLD: assert property (!wr_stb && !rd_stb
    |=> $stable(address_counter) && $stable(display_offset))
    else $error("state moved while idle");
  AST_READ_NO_SHIFT: assert property (rd_stb && reg_select
    |=> $stable(display_offset)) else $error("read shifted display");
endmodule : cdid_core_chk

bind cdid_core cdid_core_chk u_chk (
  .clk(clk), .resetn(resetn), .reg_select(reg_select), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata), .display_on(display_on),
  .cursor_on(cursor_on), .blink_on(blink_on),
  .bus_width_sel(bus_width_sel), .two_lines(two_lines),
  .luminance_hi(luminance_hi), .luminance_lo(luminance_lo),
  .display_offset(display_offset), .address_counter(address_counter)
);

// file: tb/cdid_host.sv
// Purpose: host processor model driving the access port
// Assumes: tasks are entered just after a rising edge
// Notes:   no busy poll ever; idle() gives a slow host its gaps
`timescale 1ns/1ns
module cdid_host (
  // clock and bus mode
  input wire logic       clk,
  input wire logic       bus_width_sel,
  // access port
  output logic           reg_select,
  output logic           wr_stb,
  output logic           rd_stb,
  output logic     [7:0] wdata,
  input wire logic [7:0] rdata
);
  // quiet bus at time zero
  initial begin
    reg_select = 1'b0;
    wr_stb     = 1'b0;
    rd_stb     = 1'b0;
    wdata      = 8'h00;
  end
  // one strobe held until the edge that takes it
  task automatic pulse(input logic sel, input logic rd, input logic [7:0] d);
    reg_select <= sel;
    rd_stb     <= rd;
    wr_stb     <= !rd;
    wdata      <= d;
    @(posedge clk);
  endtask : pulse
  // released data lines flip so a stale byte is never seen
  task automatic idle();
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    wdata  <= ~wdata;
    @(posedge clk);
  endtask : idle
  // back to back writes, unused low lines carry junk in nibble mode
  task automatic wr(input logic sel, input logic [7:0] d);
    if (bus_width_sel) pulse(sel, 1'b0, d);
    else begin
      pulse(sel, 1'b0, {d[7:4], ~d[3:0]});
      pulse(sel, 1'b0, {d[3:0], ~d[7:4]});
    end
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic sel, output logic [7:0] q);
    logic [3:0] hi;
    pulse(sel, 1'b1, ~wdata);
    idle();
    q  = rdata;
    hi = rdata[7:4];
    if (!bus_width_sel) begin
      pulse(sel, 1'b1, ~wdata);
      idle();
      q = {hi, rdata[7:4]};
    end
  endtask : rd
endmodule : cdid_host

// file: tb/tb_top.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: 50 MHz clock, blink half period shortened to 8 cycles
// Notes:   row table first, then reads, scan, clear, nibbles, reset
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic sel; logic [7:0] d; logic [6:0] cnt; logic [5:0] off;}
    cdid_row_t;
  logic clk = 1'b0, resetn = 1'b0, reg_select, wr_stb, rd_stb;
  logic [7:0] wdata, rdata, scan_code, q, n;
  logic display_on, cursor_on, blink_on, bus_width_sel, two_lines;
  logic luminance_hi, luminance_lo, panel_enable, scan_is_glyph;
  logic [5:0] display_offset;
  logic [6:0] address_counter;
  logic [1:0] scan_row = 2'h0;
  logic [4:0] scan_col = 5'h00, scan_pixels;
  logic [2:0] scan_pix_row = 3'h0;
  int fails = 0, samples_checked = 0;
  // write, expected counter and offset after it
  cdid_row_t rows [18] = '{'{1,8'h41,7'h01,6'h00}, '{0,8'h07,7'h01,6'h00},
    '{1,8'h42,7'h02,6'h01}, '{0,8'h05,7'h02,6'h01}, '{1,8'h43,7'h01,6'h00},
    '{1,8'h44,7'h00,6'h27}, '{0,8'h1c,7'h01,6'h26}, '{0,8'h10,7'h00,6'h26},
    '{0,8'h02,7'h00,6'h00}, '{0,8'h4a,7'h0a,6'h00}, '{1,8'h15,7'h09,6'h00},
    '{0,8'h14,7'h0a,6'h00}, '{0,8'h06,7'h0a,6'h00}, '{1,8'h50,7'h0b,6'h00},
    '{0,8'h94,7'h14,6'h00}, '{1,8'h09,7'h15,6'h00}, '{0,8'h3f,7'h15,6'h00},
    '{0,8'h0c,7'h15,6'h00}};
  logic [7:0] exp3 [3] = '{8'h41, 8'h44, 8'h43};

  always #10 clk = ~clk;

  cdid_core #(.BLINK_HALF_CYC(8)) dut (.clk(clk), .resetn(resetn),
    .reg_select(reg_select), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wdata(wdata), .rdata(rdata), .display_on(display_on),
    .cursor_on(cursor_on), .blink_on(blink_on),
    .bus_width_sel(bus_width_sel), .two_lines(two_lines),
    .luminance_hi(luminance_hi), .luminance_lo(luminance_lo),
    .panel_enable(panel_enable), .display_offset(display_offset),
    .address_counter(address_counter), .scan_row(scan_row),
    .scan_col(scan_col), .scan_pix_row(scan_pix_row),
    .scan_code(scan_code), .scan_is_glyph(scan_is_glyph),
    .scan_pixels(scan_pixels));
  cdid_host host (.clk(clk), .bus_width_sel(bus_width_sel),
    .reg_select(reg_select), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wdata(wdata), .rdata(rdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // cut a hang short well beyond the expected 155 cycles
  initial begin
    #(20 * 20000);
    fails++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // each row is judged at the edge that takes the next row
    for (int i = 0; i < 18; i++) begin
      host.wr(rows[i].sel, rows[i].d);
      if (i > 0) check({1'b0, address_counter}, {1'b0, rows[i-1].cnt});
      if (i > 0) check({2'b0, display_offset}, {2'b0, rows[i-1].off});
    end
    host.idle();
    check({1'b0, address_counter}, 8'h15);
    host.rd(1'b0, q);
    check(q, 8'h15);
    // quarter brightness: one slot in four lit
    n = 8'h00;
    repeat (16) begin
      @(posedge clk);
      n = n + {7'h00, panel_enable};
    end
    check(n, 8'h04);
    // row 3 column 1 holds a mirrored glyph code
    scan_row <= 2'h2;
    scan_pix_row <= 3'h2;
    repeat (3) @(posedge clk);
    check(scan_code, 8'h09);
    check({3'h0, scan_pixels}, 8'h15);
    check({7'h00, scan_is_glyph}, 8'h01);
    host.wr(1'b0, 8'h80);
    for (int i = 0; i < 3; i++) begin
      host.rd(1'b1, q);
      check(q, exp3[i]);
    end
    host.wr(1'b0, 8'h8a);
    host.rd(1'b1, q);
    check(q, 8'h50);
    host.wr(1'b0, 8'h4a);
    host.rd(1'b1, q);
    check(q, 8'h15);
    // clear after a decrement mode must count up again
    host.wr(1'b0, 8'h04);
    host.wr(1'b0, 8'h01);
    host.wr(1'b1, 8'h61);
    host.idle();
    check({1'b0, address_counter}, 8'h01);
    host.wr(1'b0, 8'h94);
    host.rd(1'b1, q);
    check(q, 8'h20);
    host.wr(1'b0, 8'h4a);
    host.rd(1'b1, q);
    check(q, 8'h15);
    // cursor sits on pixel row 7 only of the cell at 0x14
    host.wr(1'b0, 8'h94);
    host.wr(1'b0, 8'h0e);
    scan_pix_row <= 3'h7;
    repeat (3) @(posedge clk);
    check({3'h0, scan_pixels}, 8'h1f);
    scan_pix_row <= 3'h6;
    repeat (3) @(posedge clk);
    check({3'h0, scan_pixels}, 8'h00);
    // blink: two full periods of 16 give 16 all-on samples
    host.wr(1'b0, 8'h0d);
    @(posedge clk);
    n = 8'h00;
    repeat (32) begin
      @(posedge clk);
      n = n + {7'h00, scan_pixels == 5'h1f};
    end
    check(n, 8'h10);
    // display off blanks the panel whatever the brightness
    host.wr(1'b0, 8'h08);
    @(posedge clk);
    n = 8'h00;
    repeat (8) begin
      @(posedge clk);
      n = n + {7'h00, panel_enable};
    end
    check(n, 8'h00);
    // nibble mode: instruction, data write and read back
    host.wr(1'b0, 8'h2c);
    host.idle();
    check({7'h00, bus_width_sel}, 8'h00);
    host.wr(1'b0, 8'h85);
    host.idle();
    check({1'b0, address_counter}, 8'h05);
    host.wr(1'b1, 8'h5a);
    host.wr(1'b0, 8'h85);
    host.rd(1'b1, q);
    check(q, 8'h5a);
    // second reset in mid-run restores every default
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({1'b0, display_on, cursor_on, blink_on, bus_width_sel, two_lines,
      luminance_hi, luminance_lo}, 8'h0c);
    check({1'b0, address_counter}, 8'h00);
    host.wr(1'b0, 8'h85);
    host.rd(1'b1, q);
    check(q, 8'h20);
    give_verdict();
  end
endmodule : tb_top
